// ---- verilog/line_unit_pkg.sv ----
// constants for the line unit common control block: register map, field
// positions, reset values, carrier-loss limits and timing counts.
// assumes a 40 MHz system clock; all users refer to names with the package scope.
package line_unit_pkg;
    // register offsets on the host port
    localparam logic [4:0] ADDR_PRIMARY = 5'h00;
    localparam logic [4:0] ADDR_SECONDARY = 5'h01;
    localparam logic [7:0] REG_RESET = 8'h00;
    // primary register fields
    localparam int PRI_STD = 7;
    localparam int PRI_UNIPOLAR = 6;
    localparam int PRI_CL_ALT = 5;
    localparam int PRI_EC_LATCH = 4;
    localparam int PRI_JSRC = 3;
    localparam int PRI_TX_FROM_J = 2;
    localparam int PRI_TX_FROM_RX = 1;
    localparam int PRI_FAILOVER = 0;
    // secondary register fields
    localparam int SEC_ALARM_SEL = 7;
    localparam int SEC_CUSTOM = 4;
    localparam int SEC_RX_SUB_DIS = 3;
    localparam int SEC_TX_SUB_DIS = 2;
    localparam int SEC_TX_EDGE = 1;
    localparam int SEC_RX_EDGE = 0;
    // unassigned bit 6 is stored as zero and reads as zero
    localparam logic [7:0] SEC_WMASK = 8'hBF;
    // synchroniser lanes
    localparam int SY_MCLK = 0;
    localparam int SY_TXC = 1;
    localparam int SY_RXC = 2;
    localparam int SY_TXP = 3;
    localparam int SY_TXN = 4;
    localparam int SY_RXP = 5;
    localparam int SY_RXN = 6;
    localparam int SY_SUBP = 7;
    localparam int SY_EDGEP = 8;
    localparam int SY_W = 9;
    // consecutive-zero limits for carrier loss
    localparam logic [11:0] CL_E1 = 12'h0FF;
    localparam logic [11:0] CL_T1 = 12'h0C0;
    localparam logic [11:0] CL_ALT_E1 = 12'h800;
    localparam logic [11:0] CL_ALT_T1 = 12'h608;
    localparam logic [11:0] CL_SAT = 12'hFFF;
    // zero-substitution run lengths (HDB3 / B8ZS)
    localparam logic [3:0] RUN_E1 = 4'h4;
    localparam logic [3:0] RUN_T1 = 4'h8;
    // internal PLL phase step: 1.544/2.048 of a 256 wheel
    localparam logic [8:0] PLL_STEP_T1 = 9'h0C1;
    localparam logic [8:0] PLL_STEP_E1 = 9'h100;
    // transmit clock loss time
    localparam int CLK_PERIOD_NS = 25;
    localparam int TXCLK_LOSS_NS = 5000;
    localparam logic [8:0] TXCLK_LOSS_CYC =
        9'((TXCLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0] RX_ZRUN_MIN = 2'h2;
endpackage : line_unit_pkg

// ---- verilog/line_unit_common_control.sv ----
// line unit common control: two control registers and the clock, carrier-loss,
// error latch, alarm, driver, substitution and edge-select datapath they steer.
// assumes host port strobes on clk_sys_i; line clocks and data pins are async.
// Functional notes
// - normal criteria: 255 E1, 192 T1 zeros
// - alternate criteria: 2048 E1, 1544 T1 zeros
// - latch strobe rise copies, clears counters next cycle
// - jitter clock from master clock or PLL
// - recovered clock may act as transmit clock
// - failover to jitter clock when tx clock stops
// - alarm pin: carrier loss or 5us tx idle
// - custom driver: square wave or open drain
// - transmit data sampled on selected clock edge
// - receive data updated on selected clock edge
// - hardware mode: one pin drives both substitution disables
// - hardware mode: one pin drives both edge selects
`timescale 1ns/1ps
module line_unit_common_control (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // host register port
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // straps and hardware-mode pins
    input wire logic hw_mode_i,
    input wire logic substitution_control_pin_i,
    input wire logic edge_select_pin_i,
    input wire logic build_out_select_hi_i,
    input wire logic build_out_select_mid_i,
    input wire logic build_out_select_lo_i,
    // line clocks
    input wire logic master_clock_i,
    input wire logic tx_clock_in_i,
    input wire logic rx_clock_i,
    // transmit side
    input wire logic tx_pos_data_i,
    input wire logic tx_neg_data_i,
    output logic line_tx_tip_o,
    output logic line_tx_tip_oe_o,
    output logic line_tx_ring_o,
    output logic line_tx_ring_oe_o,
    // receive side
    input wire logic line_rx_pos_i,
    input wire logic line_rx_neg_i,
    output logic rx_pos_data_o,
    output logic rx_neg_data_o,
    // status
    output logic carrier_loss_o,
    output logic dual_alarm_o,
    output logic jitter_attenuator_clock_o,
    output logic [15:0] error_count_o
);
    typedef struct packed {
        logic [line_unit_pkg::SY_W-1:0] s1;
        logic [line_unit_pkg::SY_W-1:0] s2;
        logic [line_unit_pkg::SY_W-1:0] s3;
        logic [7:0] pri;
        logic [7:0] sec;
        logic latch_prev;
        logic [7:0] pll_acc;
        logic jtick;
        logic [8:0] idle_cnt;
        logic tx_lost;
        logic tx_last_pol;
        logic [3:0] tx_zrun;
        logic tx_bit;
        logic sq;
        logic tip;
        logic ring;
        logic tip_oe;
        logic ring_oe;
        logic od_mode;
        logic rx_last_pol;
        logic [1:0] rx_zrun;
        logic [11:0] zero_cnt;
        logic cl;
        logic pend_p;
        logic pend_n;
        logic rx_p;
        logic rx_n;
        logic [15:0] err_cnt;
        logic [15:0] err_hold;
        logic alarm;
        logic [7:0] rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic [line_unit_pkg::SY_W-1:0] rise;
    logic [line_unit_pkg::SY_W-1:0] fall;
    logic t1;
    logic rx_sub_dis;
    logic tx_sub_dis;
    logic tx_edge_rise;
    logic rx_upd_fall;
    logic use_rx;
    logic use_j;
    logic tx_sample;
    logic rx_update;
    logic latch;
    logic [11:0] zero_limit;
    logic [3:0] run_len;
    logic [8:0] pll_sum;
    logic tx_data;
    logic rx_mark;
    logic rx_viol;
    logic rx_keep;
    logic bo_zero;

    assign rise = st_r.s2 & ~st_r.s3;
    assign fall = ~st_r.s2 & st_r.s3;
    assign t1 = st_r.pri[line_unit_pkg::PRI_STD];
    assign rx_sub_dis = hw_mode_i ? st_r.s2[line_unit_pkg::SY_SUBP]
                                  : st_r.sec[line_unit_pkg::SEC_RX_SUB_DIS];
    assign tx_sub_dis = hw_mode_i ? st_r.s2[line_unit_pkg::SY_SUBP]
                                  : st_r.sec[line_unit_pkg::SEC_TX_SUB_DIS];
    assign tx_edge_rise = hw_mode_i ? st_r.s2[line_unit_pkg::SY_EDGEP]
                                    : st_r.sec[line_unit_pkg::SEC_TX_EDGE];
    assign rx_upd_fall = hw_mode_i ? st_r.s2[line_unit_pkg::SY_EDGEP]
                                   : st_r.sec[line_unit_pkg::SEC_RX_EDGE];
    // transmit clock choice: recovered clock first, then jitter clock
    assign use_rx = st_r.pri[line_unit_pkg::PRI_TX_FROM_RX];
    assign use_j = !use_rx && (st_r.pri[line_unit_pkg::PRI_TX_FROM_J]
                   || (st_r.pri[line_unit_pkg::PRI_FAILOVER] && st_r.tx_lost));
    assign tx_sample = use_rx ? (tx_edge_rise ? rise[line_unit_pkg::SY_RXC]
                                              : fall[line_unit_pkg::SY_RXC])
                     : use_j ? st_r.jtick
                     : (tx_edge_rise ? rise[line_unit_pkg::SY_TXC]
                                     : fall[line_unit_pkg::SY_TXC]);
    assign rx_update = rx_upd_fall ? fall[line_unit_pkg::SY_RXC]
                                   : rise[line_unit_pkg::SY_RXC];
    assign latch = st_r.pri[line_unit_pkg::PRI_EC_LATCH] & ~st_r.latch_prev;
    assign zero_limit = st_r.pri[line_unit_pkg::PRI_CL_ALT]
        ? (t1 ? line_unit_pkg::CL_ALT_T1 : line_unit_pkg::CL_ALT_E1)
        : (t1 ? line_unit_pkg::CL_T1 : line_unit_pkg::CL_E1);
    assign run_len = t1 ? line_unit_pkg::RUN_T1 : line_unit_pkg::RUN_E1;
    assign pll_sum = {1'b0, st_r.pll_acc}
        + (t1 ? line_unit_pkg::PLL_STEP_T1 : line_unit_pkg::PLL_STEP_E1);
    assign tx_data = st_r.pri[line_unit_pkg::PRI_UNIPOLAR] ? st_r.s2[line_unit_pkg::SY_TXP]
        : (st_r.s2[line_unit_pkg::SY_TXP] | st_r.s2[line_unit_pkg::SY_TXN]);
    assign rx_mark = st_r.s2[line_unit_pkg::SY_RXP] | st_r.s2[line_unit_pkg::SY_RXN];
    assign rx_viol = rx_mark && (st_r.s2[line_unit_pkg::SY_RXP] == st_r.rx_last_pol);
    assign rx_keep = !(rx_viol && !rx_sub_dis);
    assign bo_zero = !(build_out_select_hi_i | build_out_select_mid_i | build_out_select_lo_i);

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {edge_select_pin_i, substitution_control_pin_i, line_rx_neg_i,
                     line_rx_pos_i, tx_neg_data_i, tx_pos_data_i, rx_clock_i,
                     tx_clock_in_i, master_clock_i};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.jtick = 1'b0;
        // host port
        if (wr_i && addr_i == line_unit_pkg::ADDR_PRIMARY) begin
            st_nxt.pri = wdata_i;
        end else if (wr_i && addr_i == line_unit_pkg::ADDR_SECONDARY) begin
            st_nxt.sec = wdata_i & line_unit_pkg::SEC_WMASK;
        end
        if (rd_i) begin
            if (addr_i == line_unit_pkg::ADDR_PRIMARY) begin
                st_nxt.rdata = st_r.pri;
            end else if (addr_i == line_unit_pkg::ADDR_SECONDARY) begin
                st_nxt.rdata = st_r.sec;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
        // jitter attenuator clock
        if (rise[line_unit_pkg::SY_MCLK]) begin
            if (!st_r.pri[line_unit_pkg::PRI_JSRC]) begin
                st_nxt.jtick = 1'b1;
            end else begin
                st_nxt.pll_acc = pll_sum[7:0];
                st_nxt.jtick = pll_sum[8];
            end
        end
        // transmit clock activity watch
        if (rise[line_unit_pkg::SY_TXC] | fall[line_unit_pkg::SY_TXC]) begin
            st_nxt.idle_cnt = 9'h000;
        end else if (st_r.idle_cnt < line_unit_pkg::TXCLK_LOSS_CYC) begin
            st_nxt.idle_cnt = st_r.idle_cnt + 9'h001;
        end
        st_nxt.tx_lost = st_r.idle_cnt >= line_unit_pkg::TXCLK_LOSS_CYC;
        // transmit encoder and driver
        if (tx_sample) begin
            st_nxt.tx_bit = tx_data;
            st_nxt.sq = ~st_r.sq;
            st_nxt.tip = 1'b0;
            st_nxt.ring = 1'b0;
            if (tx_data) begin
                st_nxt.tx_last_pol = ~st_r.tx_last_pol;
                st_nxt.tip = ~st_r.tx_last_pol;
                st_nxt.ring = st_r.tx_last_pol;
                st_nxt.tx_zrun = 4'h0;
            end else if (!tx_sub_dis && st_r.tx_zrun == run_len - 4'h1) begin
                // violation repeats the polarity of the last mark
                st_nxt.tip = st_r.tx_last_pol;
                st_nxt.ring = ~st_r.tx_last_pol;
                st_nxt.tx_zrun = 4'h0;
            end else if (st_r.tx_zrun != 4'hF) begin
                st_nxt.tx_zrun = st_r.tx_zrun + 4'h1;
            end
            st_nxt.od_mode = st_r.sec[line_unit_pkg::SEC_CUSTOM] && !bo_zero;
            st_nxt.tip_oe = 1'b1;
            st_nxt.ring_oe = 1'b1;
            if (st_r.sec[line_unit_pkg::SEC_CUSTOM] && bo_zero) begin
                st_nxt.tip = ~st_r.sq;
                st_nxt.ring = st_r.sq;
            end else if (st_r.sec[line_unit_pkg::SEC_CUSTOM]) begin
                st_nxt.tip_oe = st_nxt.tip;
                st_nxt.ring_oe = st_nxt.ring;
            end
        end
        // receive decoder, zero counting and errors
        if (rise[line_unit_pkg::SY_RXC]) begin
            if (rx_mark) begin
                st_nxt.rx_last_pol = st_r.s2[line_unit_pkg::SY_RXP];
                st_nxt.rx_zrun = 2'h0;
                st_nxt.zero_cnt = 12'h000;
                if (st_r.pri[line_unit_pkg::PRI_UNIPOLAR]) begin
                    st_nxt.pend_p = rx_keep;
                    st_nxt.pend_n = 1'b0;
                end else begin
                    st_nxt.pend_p = rx_keep & st_r.s2[line_unit_pkg::SY_RXP];
                    st_nxt.pend_n = rx_keep & ~st_r.s2[line_unit_pkg::SY_RXP];
                end
                if (rx_viol && (rx_sub_dis || st_r.rx_zrun < line_unit_pkg::RX_ZRUN_MIN)
                    && st_r.err_cnt != 16'hFFFF) begin
                    st_nxt.err_cnt = st_r.err_cnt + 16'h0001;
                end
            end else begin
                st_nxt.pend_p = 1'b0;
                st_nxt.pend_n = 1'b0;
                if (st_r.rx_zrun != 2'h3) begin
                    st_nxt.rx_zrun = st_r.rx_zrun + 2'h1;
                end
                if (st_r.zero_cnt != line_unit_pkg::CL_SAT) begin
                    st_nxt.zero_cnt = st_r.zero_cnt + 12'h001;
                end
            end
        end
        if (rx_update) begin
            st_nxt.rx_p = st_r.pend_p;
            st_nxt.rx_n = st_r.pend_n;
        end
        st_nxt.cl = st_r.zero_cnt >= zero_limit;
        st_nxt.alarm = (!hw_mode_i && st_r.sec[line_unit_pkg::SEC_ALARM_SEL])
                       ? st_r.tx_lost : st_r.cl;
        // error count latch takes the cycle after the strobe rises
        st_nxt.latch_prev = st_r.pri[line_unit_pkg::PRI_EC_LATCH];
        if (latch) begin
            st_nxt.err_hold = st_r.err_cnt;
            st_nxt.err_cnt = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign line_tx_tip_o = st_r.tip;
    assign line_tx_tip_oe_o = st_r.tip_oe;
    assign line_tx_ring_o = st_r.ring;
    assign line_tx_ring_oe_o = st_r.ring_oe;
    assign rx_pos_data_o = st_r.rx_p;
    assign rx_neg_data_o = st_r.rx_n;
    assign carrier_loss_o = st_r.cl;
    assign dual_alarm_o = st_r.alarm;
    assign jitter_attenuator_clock_o = st_r.jtick;
    assign error_count_o = st_r.err_hold;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    sequence strobe_rise_s;
        $rose(st_r.pri[line_unit_pkg::PRI_EC_LATCH]);
    endsequence
    sequence counts_moved_s;
        error_count_o == $past(st_r.err_cnt) && st_r.err_cnt == 16'h0000;
    endsequence

    err_latch_a: assert property (strobe_rise_s ##1 1'b1 |-> counts_moved_s)
        else $error("error counts not latched after strobe");
    cl_normal_a: assert property ((!st_r.pri[5] && !st_r.pri[7] && st_r.zero_cnt >= 12'h0FF) [*2]
        |-> carrier_loss_o)
        else $error("carrier loss missing after E1 zero run");
    cl_alt_a: assert property ((st_r.pri[5] && st_r.pri[7] && st_r.zero_cnt < 12'h608) [*2]
        |-> !carrier_loss_o)
        else $error("carrier loss too early under T1 alternate limit");
    alarm_pin_a: assert property (##1 (dual_alarm_o == (($past(hw_mode_i) || !$past(st_r.sec[7]))
        ? $past(st_r.cl) : $past(st_r.tx_lost))))
        else $error("alarm pin shows wrong source");
    tx_lost_a: assert property ($rose(st_r.tx_lost)
        |-> $past(st_r.idle_cnt) == line_unit_pkg::TXCLK_LOSS_CYC)
        else $error("tx clock loss not at five microseconds");
    jclk_direct_a: assert property (!st_r.pri[3] && rise[0] |=> jitter_attenuator_clock_o)
        else $error("jitter clock missed a master clock edge");
    tx_sample_a: assert property (tx_sample |=> st_r.tx_bit == $past(tx_data))
        else $error("tx data not sampled on selected edge");
    rx_edge_a: assert property ($changed(rx_pos_data_o) |-> $past(rx_update))
        else $error("rx data changed off the selected edge");
    od_drive_a: assert property (st_r.od_mode |-> line_tx_tip_oe_o == line_tx_tip_o)
        else $error("open drain tip driven while high");
    hw_merge_a: assert property (hw_mode_i |-> rx_sub_dis == tx_sub_dis
        && tx_edge_rise == rx_upd_fall)
        else $error("hardware mode controls not merged");
endmodule : line_unit_common_control

// ---- dv/line_unit_common_control_test.sv ----
// self-checking bench for the line unit common control block
// assumes the design's host port, line pins and package constants
`timescale 1ns/1ps
module line_unit_common_control_test;
    localparam int HP = 6;
    localparam logic [4:0] A_PRI = line_unit_pkg::ADDR_PRIMARY;
    localparam logic [4:0] A_SEC = line_unit_pkg::ADDR_SECONDARY;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic hw_mode_i = 1'b0;
    logic bo_lo = 1'b0;
    logic mclk = 1'b0;
    logic txc = 1'b0;
    logic rxc = 1'b0;
    logic txp = 1'b0;
    logic rxp = 1'b0;
    logic rxn = 1'b0;
    logic [7:0] rdata_o;
    logic tip, tip_oe, ring, ring_oe, cl, alarm, jclk, pv;
    logic rxd_p, rxd_n;
    logic [15:0] error_count_o;
    logic [11:0] lim [4];
    logic [7:0] r;
    int mismatches = 0;
    int check_count = 0;
    int jpulses = 0;
    int j0;

    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (jclk === 1'b1) jpulses <= jpulses + 1;

    line_unit_common_control i_dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hw_mode_i(hw_mode_i),
        .substitution_control_pin_i(1'b0), .edge_select_pin_i(1'b0),
        .build_out_select_hi_i(1'b0), .build_out_select_mid_i(1'b0),
        .build_out_select_lo_i(bo_lo), .master_clock_i(mclk), .tx_clock_in_i(txc),
        .rx_clock_i(rxc), .tx_pos_data_i(txp), .tx_neg_data_i(1'b0),
        .line_tx_tip_o(tip), .line_tx_tip_oe_o(tip_oe), .line_tx_ring_o(ring),
        .line_tx_ring_oe_o(ring_oe), .line_rx_pos_i(rxp), .line_rx_neg_i(rxn),
        .rx_pos_data_o(rxd_p), .rx_neg_data_o(rxd_n), .carrier_loss_o(cl), .dual_alarm_o(alarm),
        .jitter_attenuator_clock_o(jclk), .error_count_o(error_count_o)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        cyc(1);
        d = rdata_o;
    endtask : rd

    // latch strobe: clear then set the primary strobe bit, then wait 40 system clocks
    task automatic latch();
        wr(A_PRI, 8'h00);
        wr(A_PRI, 8'h10);
        cyc(40);
    endtask : latch

    // one receive bit; marks ride on the rising recovered clock edge
    task automatic rx_bit(input logic p, input logic n);
        @(posedge clk_sys_i);
        rxp <= p;
        rxn <= n;
        rxc <= 1'b1;
        repeat (HP) @(posedge clk_sys_i);
        rxc <= 1'b0;
        cyc(HP);
    endtask : rx_bit

    // one transmit bit; data changes mid low phase so each edge sees a different bit
    task automatic tx_bit(input logic p);
        @(posedge clk_sys_i);
        txc <= 1'b0;
        repeat (HP / 2) @(posedge clk_sys_i);
        txp <= p;
        repeat (HP / 2) @(posedge clk_sys_i);
        txc <= 1'b1;
        cyc(HP);
    endtask : tx_bit

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    initial begin
        repeat (80000) @(posedge clk_sys_i);
        mismatches++;
        results();
    end

    initial begin
        lim = '{line_unit_pkg::CL_E1, line_unit_pkg::CL_T1,
                line_unit_pkg::CL_ALT_E1, line_unit_pkg::CL_ALT_T1};
        repeat (5) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rd(A_PRI, r);
        chk(16'(r), 16'(line_unit_pkg::REG_RESET), "primary reset");
        rd(A_SEC, r);
        chk(16'(r), 16'(line_unit_pkg::REG_RESET), "secondary reset");
        wr(A_PRI, 8'hA5);
        wr(A_SEC, 8'hBF);
        wr(5'h02, 8'h5A);
        rd(A_PRI, r);
        chk(16'(r), 16'h00A5, "primary readback");
        rd(A_SEC, r);
        chk(16'(r), 16'(8'hBF & line_unit_pkg::SEC_WMASK), "secondary readback");
        rd(5'h02, r);
        chk(16'(r), 16'h0000, "unmapped read");
        wr(A_PRI, 8'h00);
        for (int s = 1; s >= 0; s--) begin
            wr(A_SEC, s[0] ? 8'h06 : 8'h04);
            tx_bit(1'b0);
            tx_bit(1'b1);
            chk(16'(tip | ring), 16'(s[0]), "tx edge mark");
            tx_bit(1'b0);
            chk(16'(tip | ring), 16'(!s[0]), "tx edge space");
        end
        wr(A_SEC, 8'h06);
        tx_bit(1'b1);
        pv = tip;
        for (int i = 0; i < 3; i++) begin
            tx_bit(1'b1);
            chk(16'({tip, ring}), 16'({~pv, pv}), "ami alternation");
            pv = tip;
        end
        for (int t = 0; t < 2; t++) begin
            wr(A_PRI, t[0] ? 8'h80 : 8'h00);
            wr(A_SEC, 8'h02);
            tx_bit(1'b1);
            pv = tip;
            for (int i = 1; i < (t[0] ? 8 : 4); i++) begin
                tx_bit(1'b0);
                chk(16'(tip | ring), 16'h0000, "zero before substitution");
            end
            tx_bit(1'b0);
            chk(16'({tip, ring}), 16'({pv, ~pv}), "substituted violation");
        end
        wr(A_PRI, 8'h00);
        wr(A_SEC, 8'h16);
        bo_lo <= 1'b1;
        tx_bit(1'b1);
        chk(16'({tip_oe, ring_oe}), 16'({tip, ring}), "open drain enable");
        bo_lo <= 1'b0;
        wr(A_PRI, 8'h02);
        wr(A_SEC, 8'h06);
        pv = tip;
        rx_bit(1'b0, 1'b0);
        chk(16'({tip, ring}), 16'({~pv, pv}), "rx clock times tx");
        wr(A_PRI, 8'h00);
        wr(A_SEC, 8'h80);
        tx_bit(1'b0);
        cyc(int'(line_unit_pkg::TXCLK_LOSS_CYC) - 20);
        chk(16'(alarm), 16'h0000, "alarm before idle time");
        cyc(40);
        chk(16'(alarm), 16'h0001, "alarm after idle time");
        @(posedge clk_sys_i);
        hw_mode_i <= 1'b1;
        cyc(4);
        chk(16'(alarm), 16'h0000, "hw mode alarm select");
        @(posedge clk_sys_i);
        hw_mode_i <= 1'b0;
        wr(A_SEC, 8'h00);
        rx_bit(1'b0, 1'b1);
        latch();
        rx_bit(1'b1, 1'b0);
        repeat (3) rx_bit(1'b0, 1'b0);
        rx_bit(1'b1, 1'b0);
        rx_bit(1'b1, 1'b0);
        latch();
        chk(error_count_o, 16'h0001, "decoded errors");
        wr(A_SEC, 8'h08);
        rx_bit(1'b0, 1'b1);
        repeat (3) rx_bit(1'b0, 1'b0);
        rx_bit(1'b0, 1'b1);
        latch();
        chk(error_count_o, 16'h0001, "raw violation errors");
        latch();
        chk(error_count_o, 16'h0000, "counter cleared");
        wr(A_SEC, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(A_PRI, {i[0], 1'b0, i[1], 5'h00});
            rx_bit(1'b1, 1'b0);
            repeat (int'(lim[i]) - 1) rx_bit(1'b0, 1'b0);
            chk(16'(cl), 16'h0000, "carrier present");
            rx_bit(1'b0, 1'b0);
            chk(16'(cl), 16'h0001, "carrier lost");
            chk(16'(alarm), 16'h0001, "alarm shows carrier loss");
        end
        rx_bit(1'b0, 1'b1);
        rx_bit(1'b0, 1'b0);
        chk(16'({rxd_p, rxd_n}), 16'h0001, "rx update on rising edge");
        wr(A_SEC, 8'h01);
        rx_bit(1'b1, 1'b0);
        chk(16'({rxd_p, rxd_n}), 16'h0002, "rx update on falling edge");
        wr(A_SEC, 8'h00);
        txp <= 1'b1;
        wr(A_PRI, 8'h04);
        j0 = jpulses;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_sys_i);
            mclk <= ~mclk;
            repeat (2) @(posedge clk_sys_i);
        end
        cyc(6);
        chk(16'(jpulses - j0), 16'd10, "jitter pulses from master");
        chk(16'(tip | ring), 16'h0001, "jitter clock times tx");
        results();
    end
endmodule : line_unit_common_control_test
